// ==== pkg/psc_pkg.sv ====
package psc_pkg;

   // Program counter, page, stack and cycle geometry.
   localparam int PC_W = 10;
   localparam int PAGE_W = 2;
   localparam int PADDR_W = PC_W + PAGE_W;
   localparam int STACK_DEPTH = 5;
   localparam int STACK_PTR_W = 3;
   localparam logic [PC_W-1:0] PC_RESET = 10'h3ff;
   localparam logic [PC_W-1:0] PC_ONE = 10'h001;
   localparam int CYCLE_CLKS = 2;

   // Sequencer operations presented on the instruction port.
   typedef enum logic [2:0] {
      PSC_OP_NEXT = 3'h0,
      PSC_OP_JUMP = 3'h1,
      PSC_OP_CALL = 3'h2,
      PSC_OP_RET = 3'h3,
      PSC_OP_ADD_PC = 3'h4,
      PSC_OP_MOV_PC = 3'h5,
      PSC_OP_WRITE_PC = 3'h6
   } psc_op_t;

   // Data memory locations, by register index.
   localparam logic [5:0] LOC_INDIRECT = 6'h00;
   localparam logic [5:0] LOC_TIMER = 6'h01;
   localparam logic [5:0] LOC_PC = 6'h02;
   localparam logic [5:0] LOC_STATUS = 6'h03;
   localparam logic [5:0] LOC_RAM_SEL = 6'h04;
   localparam logic [5:0] LOC_PORT5 = 6'h05;
   localparam logic [5:0] LOC_PORT6 = 6'h06;
   localparam logic [5:0] LOC_PORT7 = 6'h07;
   localparam logic [5:0] LOC_GP_LO = 6'h08;
   localparam logic [5:0] LOC_BANK_LO = 6'h20;
   localparam logic [5:0] LOC_INT_STATUS = 6'h3f;

   // Control page locations.
   localparam logic [5:0] IOC_TIMER_CTRL = 6'h01;
   localparam logic [5:0] IOC_DIR5 = 6'h05;
   localparam logic [5:0] IOC_DIR6 = 6'h06;
   localparam logic [5:0] IOC_DIR7 = 6'h07;
   localparam logic [5:0] IOC_WAKE6 = 6'h0b;
   localparam logic [5:0] IOC_WDT_SLEEP = 6'h0e;
   localparam logic [5:0] IOC_INT_MASK = 6'h0f;

   // Bus index map: data page, control page, sequencer status.
   localparam logic [7:0] IDX_IOC_BASE = 8'h40;
   localparam logic [7:0] IDX_SEQ_STATUS = 8'h50;
   localparam int PADDR_BITS = 10;

   // Field positions.
   localparam int ST_SPARE = 7;
   localparam int ST_PS_HI = 6;
   localparam int ST_PS_LO = 5;
   localparam int TC_SRC = 5;
   localparam int TC_EDGE = 4;
   localparam int TC_PAB = 3;
   localparam int TC_PSR_HI = 2;
   localparam int INT_EXT = 3;
   localparam int INT_TMR = 0;
   localparam int RS_BANK_HI = 7;
   localparam int RS_BANK_LO = 6;

   // Reset values of the byte registers, the implemented interrupt bits and a byte increment.
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] RESET_ONES = 8'hff;
   localparam logic [7:0] INT_IMPL_MASK = 8'h09;
   localparam logic [7:0] BYTE_ONE = 8'h01;

endpackage

// ==== rtl/psc_cycle_gen.sv ====
`timescale 1ns/1ps
module psc_cycle_gen #(
   parameter int CLKS = psc_pkg::CYCLE_CLKS
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic rc_mode_i,
   output logic tick_o,
   output logic inst_clk_o,
   output logic osc_out_o,
   output logic osc_out_oe_o
);
   import psc_pkg::*;

   logic [3:0] cnt;

   // Divides the core clock into instruction cycles of CLKS clocks.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt <= 4'h0;
      end else if (cnt == 4'(CLKS - 1)) begin
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end

   // One-clock tick at the end of each instruction cycle, plus a square cycle clock.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_o <= 1'b0;
         inst_clk_o <= 1'b0;
      end else begin
         tick_o <= (cnt == 4'(CLKS - 1));
         inst_clk_o <= (cnt < 4'(CLKS / 2));
      end
   end

   // In RC mode the oscillator output pin carries the instruction clock.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         osc_out_o <= 1'b0;
         osc_out_oe_o <= 1'b0;
      end else begin
         osc_out_o <= rc_mode_i & (cnt < 4'(CLKS / 2));
         osc_out_oe_o <= rc_mode_i;
      end
   end
endmodule

// ==== rtl/psc_core.sv ====
`timescale 1ns/1ps
module psc_core #(
   parameter int CLKS = psc_pkg::CYCLE_CLKS,
   parameter int DEPTH = psc_pkg::STACK_DEPTH
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [psc_pkg::PADDR_BITS-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic op_valid_i,
   input wire psc_pkg::psc_op_t op_code_i,
   input wire logic [psc_pkg::PC_W-1:0] op_target_i,
   input wire logic [7:0] op_data_i,
   output logic op_taken_o,
   output logic op_ready_o,
   output logic [psc_pkg::PADDR_W-1:0] prog_addr_o,
   input wire logic timer_pin_i,
   input wire logic ext_int_n_i,
   output logic int_request_o,
   input wire logic rc_mode_i,
   output logic osc_out_o,
   output logic osc_out_oe_o
);
   import psc_pkg::*;

   typedef enum logic [1:0] {
      PSC_ST_RUN = 2'b01,
      PSC_ST_EXTRA = 2'b10
   } psc_state_t;

   psc_state_t state;
   logic tick;
   logic [PC_W-1:0] pc;
   logic [PAGE_W-1:0] page;
   logic [PC_W-1:0] stack [DEPTH];
   logic [PAGE_W-1:0] stack_page [DEPTH];
   logic [STACK_PTR_W-1:0] sp;
   logic [STACK_PTR_W-1:0] depth;
   logic [7:0] timer_count;
   logic [7:0] timer_control;
   logic [7:0] prescale;
   logic [7:0] status_flags;
   logic [7:0] ram_select;
   logic [7:0] port_data [3];
   logic [7:0] port_dir [3];
   logic [7:0] wake6;
   logic [7:0] wdt_sleep;
   logic [7:0] interrupt_mask;
   logic [7:0] interrupt_status;
   logic [7:0] common_mem [LOC_GP_LO:LOC_BANK_LO-6'h01];
   logic [7:0] bank_mem [128];
   logic timer_pin_q;
   logic ext_int_q;

   // Bus decode signals.
   logic bus_acc;
   logic bus_wr;
   logic [7:0] idx;
   logic is_r_page;
   logic is_ioc_page;
   logic [5:0] ioc_loc;
   logic [5:0] eff_loc;
   logic [1:0] bank;
   logic wr_loc;
   logic wr_ioc;
   logic mapped;
   logic [7:0] wbyte;
   logic [7:0] loc_rdata;
   logic [7:0] ioc_rdata;
   logic [31:0] next_prdata;

   // Sequencer and timer signals.
   logic op_fire;
   logic pc_change;
   logic [PC_W-1:0] pc_inc;
   logic [PC_W-1:0] next_pc;
   logic [PAGE_W-1:0] next_page;
   logic [STACK_PTR_W-1:0] sp_top;
   logic [STACK_PTR_W-1:0] sp_up;
   logic pin_edge;
   logic count_evt;
   logic [7:0] pre_inc;
   logic [7:0] pre_mask;
   logic timer_step;
   logic timer_ovf;
   logic ext_fall;

   psc_cycle_gen #(
      .CLKS(CLKS)
   ) u_cycle (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .rc_mode_i(rc_mode_i),
      .tick_o(tick),
      .inst_clk_o(),
      .osc_out_o(osc_out_o),
      .osc_out_oe_o(osc_out_oe_o)
   );

   // Address decode; the answer comes one clock into the access phase.
   assign bus_acc = psel_i & penable_i & ~pready_o;
   assign bus_wr = bus_acc & pwrite_i;
   assign idx = paddr_i[PADDR_BITS-1:2];
   assign is_r_page = (idx < IDX_IOC_BASE);
   assign is_ioc_page = (idx >= IDX_IOC_BASE) && (idx < IDX_SEQ_STATUS);
   assign ioc_loc = 6'(idx - IDX_IOC_BASE);
   assign wbyte = pwdata_i[7:0];
   assign bank = ram_select[RS_BANK_HI:RS_BANK_LO];
   // The indirect port has no storage of its own; it redirects to the location held in RAM select.
   assign eff_loc = (idx[5:0] == LOC_INDIRECT) ? ram_select[5:0] : idx[5:0];
   assign wr_loc = bus_wr & is_r_page;
   assign wr_ioc = bus_wr & is_ioc_page;

   // Data page read mux, addressed by the effective location.
   always_comb begin
      loc_rdata = RESET_BYTE;
      if (eff_loc == LOC_TIMER) begin
         loc_rdata = timer_count;
      end else if (eff_loc == LOC_PC) begin
         loc_rdata = pc[7:0];
      end else if (eff_loc == LOC_STATUS) begin
         loc_rdata = status_flags;
      end else if (eff_loc == LOC_RAM_SEL) begin
         loc_rdata = ram_select;
      end else if (eff_loc >= LOC_PORT5 && eff_loc <= LOC_PORT7) begin
         loc_rdata = port_data[2'(eff_loc - LOC_PORT5)];
      end else if (eff_loc == LOC_INT_STATUS) begin
         loc_rdata = interrupt_status & interrupt_mask;
      end else if (eff_loc >= LOC_BANK_LO) begin
         loc_rdata = bank_mem[{bank, eff_loc[4:0]}];
      end else if (eff_loc >= LOC_GP_LO) begin
         loc_rdata = common_mem[eff_loc];
      end
   end

   // Control page read mux; reserved locations read zero.
   always_comb begin
      ioc_rdata = RESET_BYTE;
      unique case (ioc_loc)
         IOC_TIMER_CTRL: ioc_rdata = timer_control;
         IOC_DIR5: ioc_rdata = port_dir[0];
         IOC_DIR6: ioc_rdata = port_dir[1];
         IOC_DIR7: ioc_rdata = port_dir[2];
         IOC_WAKE6: ioc_rdata = wake6;
         IOC_WDT_SLEEP: ioc_rdata = wdt_sleep;
         IOC_INT_MASK: ioc_rdata = interrupt_mask;
         default: ioc_rdata = RESET_BYTE;
      endcase
   end

   // Word returned to the bus, and whether the index is mapped at all.
   always_comb begin
      mapped = is_r_page | is_ioc_page | (idx == IDX_SEQ_STATUS);
      next_prdata = 32'h0000_0000;
      if (is_r_page) begin
         next_prdata = {24'h00_0000, loc_rdata};
      end else if (is_ioc_page) begin
         next_prdata = {24'h00_0000, ioc_rdata};
      end else if (idx == IDX_SEQ_STATUS) begin
         next_prdata = {15'h0000, depth, state == PSC_ST_EXTRA, 1'b0, page, pc};
      end
   end

   // APB answer with one wait state; unmapped indices flag an error.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= bus_acc;
         pslverr_o <= bus_acc & ~mapped;
         if (bus_acc && !pwrite_i) begin
            prdata_o <= next_prdata;
         end
      end
   end

   // Software-owned byte registers on both pages.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         status_flags <= RESET_BYTE;
         ram_select <= RESET_BYTE;
         timer_control <= RESET_BYTE;
         wake6 <= RESET_ONES;
         wdt_sleep <= RESET_BYTE;
         interrupt_mask <= RESET_BYTE;
      end else begin
         if (wr_loc && eff_loc == LOC_STATUS) begin
            status_flags <= wbyte;
         end
         if (wr_loc && eff_loc == LOC_RAM_SEL) begin
            ram_select <= wbyte;
         end
         if (wr_ioc && ioc_loc == IOC_TIMER_CTRL) begin
            timer_control <= wbyte;
         end
         if (wr_ioc && ioc_loc == IOC_WAKE6) begin
            wake6 <= wbyte;
         end
         if (wr_ioc && ioc_loc == IOC_WDT_SLEEP) begin
            wdt_sleep <= wbyte;
         end
         if (wr_ioc && ioc_loc == IOC_INT_MASK) begin
            interrupt_mask <= wbyte & INT_IMPL_MASK;
         end
      end
   end

   // Port data and direction registers, one pair per port.
   for (genvar p = 0; p < 3; p++) begin : g_port
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            port_data[p] <= RESET_BYTE;
            port_dir[p] <= RESET_ONES;
         end else begin
            if (wr_loc && eff_loc == 6'(LOC_PORT5 + 6'(p))) begin
               port_data[p] <= wbyte;
            end
            if (wr_ioc && ioc_loc == 6'(IOC_DIR5 + 6'(p))) begin
               port_dir[p] <= wbyte;
            end
         end
      end
   end

   // General registers: one common block, one banked block.
   always_ff @(posedge clk_i) begin
      if (wr_loc && eff_loc >= LOC_GP_LO && eff_loc < LOC_BANK_LO) begin
         common_mem[eff_loc] <= wbyte;
      end
      if (wr_loc && eff_loc >= LOC_BANK_LO && eff_loc < LOC_INT_STATUS) begin
         bank_mem[{bank, eff_loc[4:0]}] <= wbyte;
      end
   end

   // Timer source: cycle tick, or the chosen edge of the timer pin.
   assign pin_edge = timer_control[TC_EDGE] ? (timer_pin_q & ~timer_pin_i)
                                            : (~timer_pin_q & timer_pin_i);
   assign count_evt = timer_control[TC_SRC] ? pin_edge : tick;
   assign pre_inc = prescale + BYTE_ONE;
   assign pre_mask = 8'((16'h0002 << timer_control[TC_PSR_HI:0]) - 16'h0001);
   // With the prescaler assigned elsewhere the timer counts every event.
   assign timer_step = count_evt & (timer_control[TC_PAB] |
                                    ((pre_inc & pre_mask) == RESET_BYTE));
   assign timer_ovf = timer_step & (timer_count == RESET_ONES);
   assign ext_fall = ext_int_q & ~ext_int_n_i;

   // Input history for edge detection.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         timer_pin_q <= 1'b0;
         ext_int_q <= 1'b1;
      end else begin
         timer_pin_q <= timer_pin_i;
         ext_int_q <= ext_int_n_i;
      end
   end

   // Prescaler runs on timer events and is cleared only by a timer write.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prescale <= RESET_BYTE;
      end else if (wr_loc && eff_loc == LOC_TIMER) begin
         prescale <= RESET_BYTE;
      end else if (count_evt && !timer_control[TC_PAB]) begin
         prescale <= pre_inc;
      end
   end

   // Timer count: software write wins over a count in the same clock.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         timer_count <= RESET_BYTE;
      end else if (wr_loc && eff_loc == LOC_TIMER) begin
         timer_count <= wbyte;
      end else if (timer_step) begin
         timer_count <= timer_count + BYTE_ONE;
      end
   end

   // Interrupt flags: hardware sets, software only clears; a set beats a clear.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         interrupt_status <= RESET_BYTE;
      end else begin
         if (wr_loc && eff_loc == LOC_INT_STATUS) begin
            interrupt_status <= (interrupt_status & wbyte & INT_IMPL_MASK)
                                | {4'h0, ext_fall, 2'b00, timer_ovf};
         end else begin
            interrupt_status <= interrupt_status
                                | {4'h0, ext_fall, 2'b00, timer_ovf};
         end
      end
   end

   // Masked pending request towards the interrupt controller.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         int_request_o <= 1'b0;
      end else begin
         int_request_o <= |(interrupt_status & interrupt_mask);
      end
   end

   // Sequencer: an operation is taken at the end of a normal instruction cycle.
   assign op_fire = tick & op_valid_i & (state == PSC_ST_RUN);
   assign pc_change = op_fire & (op_code_i != PSC_OP_NEXT);
   assign pc_inc = pc + PC_ONE;
   assign sp_top = (sp == 3'(0)) ? 3'(DEPTH - 1) : sp - 3'(1);
   assign sp_up = (sp == 3'(DEPTH - 1)) ? 3'(0) : sp + 3'(1);

   // Next counter and page for each operation.
   always_comb begin
      next_pc = pc;
      next_page = page;
      if (op_fire) begin
         unique case (op_code_i)
            PSC_OP_NEXT: next_pc = pc_inc;
            PSC_OP_JUMP, PSC_OP_CALL: begin
               next_pc = op_target_i;
               next_page = status_flags[ST_PS_HI:ST_PS_LO];
            end
            PSC_OP_RET: begin
               next_pc = stack[sp_top];
               next_page = stack_page[sp_top];
            end
            PSC_OP_ADD_PC: begin
               next_pc = {2'b00, pc_inc[7:0] + op_data_i};
               next_page = status_flags[ST_PS_HI:ST_PS_LO];
            end
            PSC_OP_MOV_PC, PSC_OP_WRITE_PC: begin
               next_pc = {2'b00, op_data_i};
               next_page = status_flags[ST_PS_HI:ST_PS_LO];
            end
            default: next_pc = pc_inc;
         endcase
      end
   end

   // Counter and page registers; reset holds the counter at all ones.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pc <= PC_RESET;
         page <= 2'b00;
      end else begin
         pc <= next_pc;
         page <= next_page;
      end
   end

   // Five-level circular stack of return addresses with their pages.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sp <= 3'(0);
         depth <= 3'(0);
      end else if (op_fire && op_code_i == PSC_OP_CALL) begin
         stack[sp] <= pc_inc;
         stack_page[sp] <= page;
         sp <= sp_up;
         depth <= (depth == 3'(DEPTH)) ? depth : depth + 3'(1);
      end else if (op_fire && op_code_i == PSC_OP_RET) begin
         sp <= sp_top;
         depth <= (depth == 3'(0)) ? depth : depth - 3'(1);
      end
   end

   // Any operation other than NEXT costs one more instruction cycle.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= PSC_ST_RUN;
      end else begin
         unique case (state)
            PSC_ST_RUN: begin
               if (pc_change) begin
                  state <= PSC_ST_EXTRA;
               end
            end
            PSC_ST_EXTRA: begin
               if (tick) begin
                  state <= PSC_ST_RUN;
               end
            end
         endcase
      end
   end

   // Handshake and program address outputs.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         op_taken_o <= 1'b0;
         op_ready_o <= 1'b0;
         prog_addr_o <= {2'b00, PC_RESET};
      end else begin
         op_taken_o <= op_fire;
         op_ready_o <= (state == PSC_ST_RUN) & ~pc_change
                       | (state == PSC_ST_EXTRA) & tick;
         prog_addr_o <= {next_page, next_pc};
      end
   end
endmodule

// ==== dv/psc_rom_model.sv ====
`timescale 1ns/1ps
// Program memory stand-in: one 13-bit word for every address of the four pages.
module psc_rom_model (
   input wire logic [psc_pkg::PADDR_W-1:0] addr_i,
   output logic [12:0] word_o
);
   import psc_pkg::*;
   logic [12:0] mem [0:4095];
   // A distinct pattern per word, so a wrong page or word shows as wrong data.
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 13'(i * 181 + 419);
      end
   end
   // Page bits pick the 1024-word quarter, counter bits the word within it.
   assign word_o = mem[addr_i];
endmodule

// ==== dv/psc_core_props.sv ====
`timescale 1ns/1ps
module psc_core_props (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic op_taken_o,
   input wire logic op_ready_o,
   input wire psc_pkg::psc_op_t op_code_i,
   input wire logic [psc_pkg::PC_W-1:0] op_target_i,
   input wire logic [7:0] op_data_i,
   input wire logic [psc_pkg::PADDR_W-1:0] prog_addr_o,
   input wire logic rc_mode_i,
   input wire logic osc_out_o,
   input wire logic osc_out_oe_o
);
   import psc_pkg::*;
   psc_op_t op_q;
   logic [PC_W-1:0] tgt_q;
   logic [7:0] dat_q;
   logic [PADDR_W-1:0] adr_q;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   // Operation fields and address as they stood at the taking edge.
   always_ff @(posedge clk_i) begin
      op_q <= op_code_i;
      tgt_q <= op_target_i;
      dat_q <= op_data_i;
      adr_q <= prog_addr_o;
   end
   reset_pc_a: assert property (disable iff (1'b0) !rstn_i |-> prog_addr_o == 12'h3ff)
      else $error("counter not at reset value");
   next_step_a: assert property (op_taken_o && op_q == PSC_OP_NEXT |->
      prog_addr_o == {adr_q[11:10], adr_q[9:0] + PC_ONE}) else $error("no step by one");
   jump_load_a: assert property (op_taken_o && op_q == PSC_OP_JUMP |->
      prog_addr_o[9:0] == tgt_q) else $error("jump target not loaded");
   call_load_a: assert property (op_taken_o && op_q == PSC_OP_CALL |->
      prog_addr_o[9:0] == tgt_q) else $error("call target not loaded");
   add_pc_a: assert property (op_taken_o && op_q == PSC_OP_ADD_PC |->
      prog_addr_o[9:0] == {2'b00, 8'(adr_q[7:0] + 8'h01 + dat_q)}) else $error("bad add");
   move_pc_a: assert property (op_taken_o && op_q inside {PSC_OP_MOV_PC, PSC_OP_WRITE_PC} |->
      prog_addr_o[9:0] == {2'b00, dat_q}) else $error("bad move");
   extra_cycle_a: assert property (op_taken_o && op_q != PSC_OP_NEXT |->
      !op_ready_o ##1 !op_taken_o [*3]) else $error("no extra cycle");
   addr_hold_a: assert property (!op_taken_o |-> $stable(prog_addr_o))
      else $error("address moved without an operation");
   apb_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("late ready");
   err_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
   rc_clock_a: assert property (rc_mode_i [*3] |-> osc_out_oe_o &&
      (osc_out_o != $past(osc_out_o) || osc_out_o != $past(osc_out_o, 2)))
      else $error("no clock on pin");
endmodule
bind psc_core psc_core_props u_props (.clk_i, .rstn_i, .psel_i, .penable_i, .pready_o,
   .pslverr_o, .op_taken_o, .op_ready_o, .op_code_i, .op_target_i, .op_data_i, .prog_addr_o,
   .rc_mode_i, .osc_out_o, .osc_out_oe_o);

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import psc_pkg::*;
   logic clk_i = 0, rstn_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic op_valid_i = 0, timer_pin_i = 0, ext_int_n_i = 1, rc_mode_i = 0, e;
   logic [9:0] paddr_i = 0, op_target_i = 0;
   logic [31:0] pwdata_i = 0, prdata_o;
   logic pready_o, pslverr_o, op_taken_o, op_ready_o, int_request_o, osc_out_o, osc_out_oe_o;
   psc_op_t op_code_i = PSC_OP_NEXT;
   logic [7:0] acc = 0, op_data_i, r;
   logic [11:0] prog_addr_o;
   logic [12:0] word;
   int fails = 0, checks_done = 0, seed = 39516, cyc = 0, pc, pg, ps, dp;
   int stk[$], q1[3];
   int lc[6] = '{1, 5, 6, 7, 11, 15};
   int tc[4] = '{8'h28, 8'h38, 8'h20, 8'h21}, tk[4] = '{5, 5, 4, 8}, tx[4] = '{5, 4, 2, 2};
   // The accumulator value mixes the fetched word with a random operand.
   assign op_data_i = word[7:0] ^ acc;
   psc_core dut (.*);
   psc_rom_model rom (.addr_i(prog_addr_o), .word_o(word));
   initial forever #4 clk_i = ~clk_i;
   // A hang is cut short after a fixed number of cycles.
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input int idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= 10'(idx * 4);
      pwdata_i <= {24'h0, d};
      @(posedge clk_i);
      penable_i <= 1;
      do @(posedge clk_i); while (pready_o !== 1'b1 && ++n < 20);
      r = prdata_o[7:0];
      e = pslverr_o;
      chk(32'(n < 20), 1);
      psel_i <= 0;
      penable_i <= 0;
   endtask
   task automatic op(input int c, input logic [9:0] t);
      int n;
      n = 0;
      repeat (2) @(posedge clk_i);
      op_code_i <= psc_op_t'(c);
      op_target_i <= t;
      acc <= 8'($random(seed));
      op_valid_i <= 1;
      do @(posedge clk_i); while (op_taken_o !== 1'b1 && ++n < 40);
      chk(32'(n < 40), 1);
      op_valid_i <= 0;
   endtask
   task automatic setps(input int p);
      logic [7:0] d;
      d = 8'({$random(seed)} % 2 * 128 + p * 32);
      apb(1, 3, d);
      apb(0, 3, 0);
      chk(r & 8'he0, d);
      ps = p;
   endtask
   task automatic rst();
      rstn_i <= 0;
      repeat (16) @(posedge clk_i);
      chk(prog_addr_o, 12'h3ff);
      rstn_i <= 1;
      pc = 1023;
      pg = 0;
      ps = 0;
      dp = 0;
      stk.delete();
   endtask
   // Reference sequencer, stepped with the fields seen at each taking edge.
   always @(posedge clk_i) begin
      if (op_taken_o === 1'b1) begin
         case (q1[0])
            PSC_OP_NEXT: pc = (pc + 1) % 1024;
            PSC_OP_RET: begin
               pg = stk[$] / 1024;
               pc = stk.pop_back() % 1024;
            end
            default: begin
               if (q1[0] == PSC_OP_CALL) stk.push_back(pg * 1024 + (pc + 1) % 1024);
               if (q1[0] == PSC_OP_ADD_PC) pc = (pc + 1 + q1[2]) % 256;
               else pc = q1[0] < 3 ? q1[1] : q1[2];
               pg = ps;
            end
         endcase
         chk(prog_addr_o, pg * 1024 + pc);
      end
      q1 = '{op_code_i, op_target_i, op_data_i};
   end
   initial begin
      int c;
      rst();
      for (int i = 0; i < 6; i++) begin
         apb(0, 64 + lc[i], 0);
         chk(r, i % 5 ? 255 : 0);
      end
      apb(1, 96, 8'h5a);
      apb(0, 96, 0);
      chk({e, r}, 9'h100);
      for (int i = 0; i < 8; i++) begin
         apb(1, 4, 8'(i % 4 * 64 + 32));
         if (i < 4) apb(1, 0, 8'(160 + i));
         else apb(0, 0, 0);
         if (i > 3) chk(r, 156 + i);
      end
      apb(1, 4, 8'hd0);
      apb(1, 0, 8'h5a);
      apb(0, 16, 0);
      chk(r, 8'h5a);
      for (int i = 0; i < 4; i++) begin
         apb(1, 65, 8'(tc[i]));
         apb(1, 1, 0);
         repeat (tk[i] * 2 - 1) begin
            timer_pin_i <= ~timer_pin_i;
            repeat (4) @(posedge clk_i);
         end
         apb(0, 1, 0);
         chk(r, tx[i]);
         timer_pin_i <= 0;
      end
      apb(1, 79, 8'h08);
      ext_int_n_i <= 0;
      repeat (6) @(posedge clk_i);
      chk(int_request_o, 1);
      apb(0, 63, 0);
      chk(r, 8'h08);
      ext_int_n_i <= 1;
      apb(1, 63, 0);
      repeat (6) @(posedge clk_i);
      chk(int_request_o, 0);
      // In cycle-tick mode two reads four clocks apart see two instruction cycles.
      apb(1, 65, 8'h08);
      apb(0, 1, 0);
      c = r;
      apb(0, 1, 0);
      chk(8'(r - c), 4 / CYCLE_CLKS);
      rc_mode_i <= 1;
      repeat (12) @(posedge clk_i);
      chk(osc_out_oe_o, 1);
      r[0] = osc_out_o;
      @(posedge clk_i);
      chk(osc_out_o ^ r[0], 1);
      rc_mode_i <= 0;
      for (int i = 0; i < 5; i++) begin
         setps(i % 4);
         op(PSC_OP_CALL, 10'($random(seed)));
      end
      repeat (5) op(PSC_OP_RET, 0);
      for (int i = 0; i < 60; i++) begin
         c = {$random(seed)} % 7;
         if (c == PSC_OP_CALL && dp == 5 || c == PSC_OP_RET && dp == 0) c = 0;
         dp += (c == PSC_OP_CALL) - (c == PSC_OP_RET);
         op(c, 10'($random(seed)));
         if (i % 8 == 7) setps({$random(seed)} % 4);
      end
      rst();
      op(PSC_OP_NEXT, 0);
      repeat (4) @(posedge clk_i);
      summarize();
   end
endmodule
